// ===== dv/beacon_side_lobe_filter_tb.sv
`timescale 1ns/1ps

module beacon_side_lobe_filter_tb;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic detect;
    logic telegram_valid;
    logic [lobe_pkg::TLG_W-1:0] telegram;
    logic telegram_restrictive;
    logic [lobe_pkg::AMP_W-1:0] strength;
    logic [lobe_pkg::POS_W-1:0] odo_mm;
    logic [lobe_pkg::POS_W-1:0] odo_conf_mm = 32'h0;
    logic [lobe_pkg::CLS_W-1:0] telegram_class = 2'h0;
    logic group_fit = 1'h0;
    logic beacon_valid;
    lobe_pkg::beacon_t beacon;
    logic restrictive_alarm;
    lobe_pkg::beacon_t exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;
    int n_alarm = 0;
    int exp_alarm = 0;
    int base = 1000;
    int m_open = 0;
    int m_s = 0;
    int m_e = 0;
    int m_pk = 0;
    int m_r = 0;
    logic [63:0] m_tel = 64'h0;

    always #4 clk = ~clk;

    beacon_side_lobe_filter u_beacon_side_lobe_filter (
        .clk(clk),
        .reset_n(reset_n),
        .detect(detect),
        .telegram_valid(telegram_valid),
        .telegram(telegram),
        .telegram_restrictive(telegram_restrictive),
        .strength(strength),
        .odo_mm(odo_mm),
        .odo_conf_mm(odo_conf_mm),
        .telegram_class(telegram_class),
        .group_fit(group_fit),
        .beacon_valid(beacon_valid),
        .beacon(beacon),
        .restrictive_alarm(restrictive_alarm)
    );

    lobe_source u_lobe_source (
        .clk(clk),
        .detect(detect),
        .telegram_valid(telegram_valid),
        .telegram(telegram),
        .telegram_restrictive(telegram_restrictive),
        .strength(strength),
        .odo_mm(odo_mm)
    );

    // ************************************************************
    // Checks and verdict
    // ************************************************************
    task automatic conclude();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_int(input string what, input int e, s);
        cmp_count++;
        if (e != s) begin
            n_fail++;
            $display("[ERR] %s exp %0d got %0d", what, e, s);
        end
    endtask

    task automatic chk_beacon(input lobe_pkg::beacon_t e, s);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] beacon exp %h got %h", e, s);
        end
    endtask

    always @(negedge clk) begin
        if (restrictive_alarm === 1'h1) begin
            n_alarm++;
        end
        if (beacon_valid === 1'h1) begin
            if (exp_q.size() == 0)
                chk_int("extra beacon", 0, 1);
            else
                chk_beacon(exp_q.pop_front(), beacon);
        end
    end

    // ************************************************************
    // Reference model
    // ************************************************************
    task automatic report();
        lobe_pkg::beacon_t b;
        b.location_mm = 32'((m_s + m_e) / 2);
        b.telegram = m_tel;
        b.restrictive = m_r[0];
        exp_q.push_back(b);
    endtask

    task automatic lobe_at(input int off, h, input logic [63:0] t,
                           input int r, pk, cls, gf);
        int c;
        int d;
        int cf;
        int nb;
        c = base + off;
        cf = int'(odo_conf_mm);
        d = c - (m_s + m_e) / 2;
        if (d < 0)
            d = -d;
        nb = (m_open == 0 || cls == 1 || d - cf > 1700
              || (d + cf >= 800 && cls == 0 && gf == 1)) ? 1 : 0;
        if (m_open != 0 && nb != 0)
            report();
        telegram_class = 2'(cls);
        group_fit = gf[0];
        exp_alarm += r;
        u_lobe_source.lobe(32'(c - h), 32'(c + h), t, r[0], 8'(pk),
                           $urandom_range(0, 5));
        chk_int("alarms", exp_alarm, n_alarm);
        // Strength decides while available, else lobe length
        if (nb != 0 || (m_pk != 0 ? pk > m_pk : 2 * h > m_e - m_s)) begin
            m_s = c - h;
            m_e = c + h;
            m_pk = pk;
            m_tel = t;
            m_r = r;
        end
        m_open = 1;
    endtask

    task automatic close_b();
        int i;
        if (m_open != 0)
            report();
        m_open = 0;
        u_lobe_source.move(32'(base + 30000));
        for (i = 0; i < 200 && exp_q.size() > 0; i++)
            @(negedge clk);
        chk_int("pending beacons", 0, exp_q.size());
        if (i == 200)
            conclude();
        base += 60000;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        int k;
        int a;
        int cf;
        int pk;
        logic [63:0] tl;
        int cl[11] = '{0, 1, 2, 3, 0, 0, 1, 2, 0, 0, 0};
        int gv[11] = '{1, 1, 1, 1, 1, 1, 0, 1, 0, 0, 0};
        void'($urandom(44));
        repeat (3) @(negedge clk);
        reset_n = 1'h1;
        repeat (4) @(negedge clk);
        lobe_at(0, 60, {$urandom, $urandom}, 1, $urandom_range(1, 255),
                0, 0);
        close_b();
        for (a = 0; a < 2; a++) begin
            tl = {$urandom, $urandom};
            lobe_at(0, 50, tl, 0, a * 40, 0, 0);
            lobe_at(300, 80, tl, 0, a * 30, 0, 0);
            lobe_at(600, 60, tl, 0, a * 90, 0, 0);
            close_b();
        end
        // Near, boundary, middle and far centre distances
        // Last case: far lobe arrives before the tail can close
        for (k = 0; k < 11; k++) begin
            cf = $urandom_range(0, 100);
            odo_conf_mm = 32'(cf);
            a = (k < 4) ? $urandom_range(200, 500) : (k == 4) ? 799 - cf
              : (k == 5) ? 800 - cf : (k < 9) ? 1200
              : (k == 9) ? 2500 : 1750 + cf;
            pk = (k % 2 != 0) ? 0 : $urandom_range(1, 127);
            tl = {$urandom, $urandom};
            lobe_at(0, $urandom_range(40, 64), tl, $urandom_range(0, 1),
                    pk, 0, 0);
            lobe_at(a, $urandom_range(66, 90), (cl[k] == 0) ? tl : ~tl,
                    $urandom_range(0, 1),
                    pk != 0 ? pk + $urandom_range(1, 100) : 0,
                    cl[k], gv[k]);
            close_b();
        end
        conclude();
    end
endmodule

// ===== dv/lobe_source.sv
`timescale 1ns/1ps

// ************************************************************
// Beacon transmission side: detection, telegram, strength, odo
// ************************************************************
module lobe_source (
    input wire logic clk,
    output logic detect,
    output logic telegram_valid,
    output logic [lobe_pkg::TLG_W-1:0] telegram,
    output logic telegram_restrictive,
    output logic [lobe_pkg::AMP_W-1:0] strength,
    output logic [lobe_pkg::POS_W-1:0] odo_mm
);
    initial begin
        detect = 1'h0;
        telegram_valid = 1'h0;
        telegram = 64'h0;
        telegram_restrictive = 1'h0;
        strength = 8'h00;
        odo_mm = 32'h0;
    end

    task automatic move(input logic [lobe_pkg::POS_W-1:0] pos);
        @(negedge clk);
        odo_mm = pos;
    endtask

    // Odometer held still round each detect edge so captures are exact
    task automatic lobe(input logic [31:0] s, e, input logic [63:0] t,
                        input logic r, input logic [7:0] pk, input int late);
        move(s);
        strength = pk;
        repeat (2) @(negedge clk);
        detect = 1'h1;
        repeat (3 + late) @(negedge clk);
        telegram = t;
        telegram_restrictive = r;
        telegram_valid = 1'h1;
        @(negedge clk);
        telegram_valid = 1'h0;
        // Stale after the pulse: show junk, not the last value
        telegram = ~t;
        telegram_restrictive = ~r;
        repeat (3) @(negedge clk);
        odo_mm = e;
        repeat (2) @(negedge clk);
        detect = 1'h0;
        repeat (10) @(negedge clk);
        strength = 8'h00;
    endtask
endmodule

// ===== hw/beacon_side_lobe_filter.sv
`timescale 1ns/1ps

// Overview of operation
// RULE1: Merge lobes so one beacon is reported
// RULE2: Restrictive aspect acted on immediately
// RULE3: Lobe extent from detection level
// RULE4: Telegram taken from telegram detection
// RULE5: Strength available when any bit nonzero
// RULE6: Highest peak becomes main lobe
// RULE7: Without strength, longest lobe is main
// RULE8: Location is main lobe midpoint
// RULE9: Telegram and location from same lobe
// RULE10: Lobes in order; first is main
// RULE11: Unproven new beacon re-judges main lobe
// RULE12: Close beacon beyond 1.7 m after end
// RULE13: Different telegrams, near: start new beacon
// RULE14: Different telegrams, not near: new beacon
// RULE15: Same telegram, near: merge lobes
// RULE16: Same telegram, middle: group check decides
// RULE17: Same telegram, far: two beacons
// RULE18: Side lobe separation limit 0.8 m
// RULE19: Distance proven across confidence interval
module beacon_side_lobe_filter #(
    parameter int AMP_W = lobe_pkg::AMP_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic detect,
    input wire logic telegram_valid,
    input wire logic [lobe_pkg::TLG_W-1:0] telegram,
    input wire logic telegram_restrictive,
    input wire logic [lobe_pkg::AMP_W-1:0] strength,
    input wire logic [lobe_pkg::POS_W-1:0] odo_mm,
    input wire logic [lobe_pkg::POS_W-1:0] odo_conf_mm,
    input wire logic [lobe_pkg::CLS_W-1:0] telegram_class,
    input wire logic group_fit,
    output logic beacon_valid,
    output lobe_pkg::beacon_t beacon,
    output logic restrictive_alarm
);

    // ************************************************************
    // Checks and reset
    // ************************************************************
    if (AMP_W != lobe_pkg::AMP_W) begin : g_amp_chk
        $error("AMP_W must match package width");
    end

    logic rst_m_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic det_m_q;
    logic det_s_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            det_m_q <= 1'b0;
            det_s_q <= 1'b0;
        end else begin
            det_m_q <= detect;
            det_s_q <= det_m_q;
        end
    end

    // Odometer and telegram come from same-clock logic
    logic lobe_valid;
    lobe_pkg::lobe_t new_lobe;
    logic restrict_pulse;
    logic lobe_active;

    lobe_measure u_measure (
        .clk(clk),
        .rst_n(rst_n_q),
        .detect(det_s_q),
        .telegram_valid(telegram_valid),
        .telegram(telegram),
        .telegram_restrictive(telegram_restrictive),
        .strength(strength),
        .odo_mm(odo_mm),
        .lobe_valid(lobe_valid),
        .lobe_q(new_lobe),
        .restrict_pulse(restrict_pulse),
        .active(lobe_active)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [lobe_pkg::POS_W-1:0] mid_of(
        input lobe_pkg::lobe_t l
    );
        logic [lobe_pkg::POS_W:0] s;
        s = {1'b0, l.start_mm} + {1'b0, l.end_mm};
        return s[lobe_pkg::POS_W:1];
    endfunction

    function automatic logic [lobe_pkg::POS_W-1:0] len_of(
        input lobe_pkg::lobe_t l
    );
        return l.end_mm - l.start_mm;
    endfunction

    function automatic logic [lobe_pkg::POS_W-1:0] absdiff(
        input logic [lobe_pkg::POS_W-1:0] a,
        input logic [lobe_pkg::POS_W-1:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction

    // Proven only if the whole interval agrees [RULE19]
    function automatic lobe_pkg::dist_t classify(
        input logic [lobe_pkg::POS_W-1:0] d,
        input logic [lobe_pkg::POS_W-1:0] c
    );
        logic [lobe_pkg::POS_W:0] hi;
        hi = {1'b0, d} + {1'b0, c};
        if (hi < {1'b0, lobe_pkg::SAME_MAX_MM}) begin // [RULE18]
            return lobe_pkg::DIST_NEAR;
        end else if (d > c
            && (d - c) > lobe_pkg::NEW_MIN_MM) begin
            return lobe_pkg::DIST_FAR;
        end
        return lobe_pkg::DIST_MID;
    endfunction

    // ************************************************************
    // Beacon state
    // ************************************************************
    logic open_q;
    logic strength_avail_q;
    lobe_pkg::lobe_t main_q;
    lobe_pkg::dist_t cls;
    lobe_pkg::dist_t tail;
    logic new_beacon;
    logic better;
    logic close_now;

    assign cls = classify(absdiff(mid_of(new_lobe), mid_of(main_q)),
        odo_conf_mm);
    assign tail = classify(absdiff(odo_mm, mid_of(main_q)), odo_conf_mm);

    // Telegram and distance decision table
    always_comb begin
        new_beacon = 1'b0;
        case (telegram_class)
            lobe_pkg::TLG_DIFF: begin
                new_beacon = 1'b1; // [RULE13] [RULE14]
            end
            lobe_pkg::TLG_SAME: begin
                if (cls == lobe_pkg::DIST_FAR) begin
                    new_beacon = 1'b1; // [RULE17]
                end else if (cls == lobe_pkg::DIST_MID) begin
                    new_beacon = group_fit; // [RULE16]
                end else begin
                    new_beacon = 1'b0; // [RULE15]
                end
            end
            default: begin
                new_beacon = (cls == lobe_pkg::DIST_FAR);
            end
        endcase
    end

    // Any nonzero strength counts as available [RULE5]
    always_comb begin
        if (strength_avail_q || (|new_lobe.peak)) begin
            better = new_lobe.peak > main_q.peak; // [RULE6]
        end else begin
            better = len_of(new_lobe) > len_of(main_q); // [RULE7]
        end
    end

    // Ended main lobe, no new lobe, proven beyond 1.7 m [RULE12]
    assign close_now = open_q && !lobe_active && !lobe_valid
        && tail == lobe_pkg::DIST_FAR;

    // Lobes taken one at a time in arrival order [RULE10]
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_q <= 1'b0;
            main_q <= '0;
            strength_avail_q <= 1'b0;
        end else if (lobe_valid) begin
            if (!open_q || new_beacon) begin
                open_q <= 1'b1;
                main_q <= new_lobe; // [RULE10]
                strength_avail_q <= |new_lobe.peak;
            end else begin
                strength_avail_q <= strength_avail_q | (|new_lobe.peak);
                if (better) begin
                    main_q <= new_lobe; // [RULE11]
                end
            end
        end else if (close_now) begin
            open_q <= 1'b0;
        end
    end

    // ************************************************************
    // Beacon report
    // ************************************************************
    // One report per beacon, on close or when a lobe starts a new beacon [RULE1]
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            beacon_valid <= 1'b0;
            beacon <= '0;
        end else begin
            beacon_valid <= close_now
                || (lobe_valid && open_q && new_beacon);
            if (close_now || (lobe_valid && open_q && new_beacon)) begin
                beacon.location_mm <= mid_of(main_q); // [RULE8]
                beacon.telegram <= main_q.telegram; // [RULE9]
                beacon.restrictive <= main_q.restrictive;
            end
        end
    end

    // Reaction does not wait for the beacon to end [RULE2]
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            restrictive_alarm <= 1'b0;
        end else begin
            restrictive_alarm <= restrict_pulse;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_alarm;
        @(posedge clk) disable iff (!rst_n_q)
        restrict_pulse |=> restrictive_alarm;
    endproperty
    a_alarm: assert property (p_alarm) // [RULE2]
        else $error("restrictive alarm missed");

    property p_one_report;
        @(posedge clk) disable iff (!rst_n_q)
        beacon_valid |=> !beacon_valid;
    endproperty
    a_one_report: assert property (p_one_report) // [RULE1]
        else $error("back to back beacon reports");

    property p_location;
        @(posedge clk) disable iff (!rst_n_q)
        close_now |=> beacon_valid
            && beacon.location_mm == mid_of($past(main_q));
    endproperty
    a_location: assert property (p_location) // [RULE8]
        else $error("location not main lobe midpoint");

    property p_merge;
        @(posedge clk) disable iff (!rst_n_q)
        (lobe_valid && open_q && telegram_class == lobe_pkg::TLG_SAME
            && cls == lobe_pkg::DIST_NEAR) |=> open_q && !beacon_valid;
    endproperty
    a_merge: assert property (p_merge) // [RULE15]
        else $error("near identical lobes not merged");

    property p_diff;
        @(posedge clk) disable iff (!rst_n_q)
        (lobe_valid && open_q && telegram_class == lobe_pkg::TLG_DIFF)
            |=> beacon_valid && main_q == $past(new_lobe);
    endproperty
    a_diff: assert property (p_diff) // [RULE14]
        else $error("different telegram did not start beacon");

    property p_far;
        @(posedge clk) disable iff (!rst_n_q)
        (lobe_valid && open_q && telegram_class == lobe_pkg::TLG_SAME
            && cls == lobe_pkg::DIST_FAR) |=> beacon_valid;
    endproperty
    a_far: assert property (p_far) // [RULE17]
        else $error("far identical lobes not split");

    property p_split_report;
        @(posedge clk) disable iff (!rst_n_q)
        (lobe_valid && open_q && new_beacon) |=> beacon_valid
            && beacon.location_mm == mid_of($past(main_q))
            && beacon.telegram == $past(main_q.telegram);
    endproperty
    a_split_report: assert property (p_split_report) // [RULE9]
        else $error("split report not from old main lobe");

    property p_close;
        @(posedge clk) disable iff (!rst_n_q)
        close_now |=> !open_q && beacon_valid ##1 !beacon_valid;
    endproperty
    a_close: assert property (p_close) // [RULE12]
        else $error("beacon not closed");

    property p_first;
        @(posedge clk) disable iff (!rst_n_q)
        (lobe_valid && !open_q) |=> open_q && main_q == $past(new_lobe);
    endproperty
    a_first: assert property (p_first) // [RULE10]
        else $error("first lobe not main");

endmodule

// ===== hw/lobe_measure.sv
`timescale 1ns/1ps

// ************************************************************
// Lobe extent, peak and telegram capture
// ************************************************************
module lobe_measure (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic detect,
    input wire logic telegram_valid,
    input wire logic [lobe_pkg::TLG_W-1:0] telegram,
    input wire logic telegram_restrictive,
    input wire logic [lobe_pkg::AMP_W-1:0] strength,
    input wire logic [lobe_pkg::POS_W-1:0] odo_mm,
    output logic lobe_valid,
    output lobe_pkg::lobe_t lobe_q,
    output logic restrict_pulse,
    output logic active
);
    logic det_q;
    lobe_pkg::lobe_t cur_q;

    assign active = det_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            det_q <= 1'b0;
        end else begin
            det_q <= detect;
        end
    end

    // Extent from the detection level [RULE3]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else if (detect) begin
            // Telegram in the first lobe cycle must not be lost
            if (!det_q) begin
                cur_q <= '0;
                cur_q.start_mm <= odo_mm;
                cur_q.peak <= strength;
            end else if (strength > cur_q.peak) begin
                cur_q.peak <= strength;
            end
            if (telegram_valid) begin // [RULE4]
                cur_q.telegram <= telegram;
                cur_q.restrictive <= telegram_restrictive;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lobe_valid <= 1'b0;
            lobe_q <= '0;
        end else begin
            lobe_valid <= det_q && !detect;
            if (det_q && !detect) begin
                lobe_q <= cur_q;
                lobe_q.end_mm <= odo_mm; // [RULE3]
            end
        end
    end

    // Act on a stop aspect within the lobe, side or main [RULE2]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restrict_pulse <= 1'b0;
        end else begin
            restrict_pulse <= detect && telegram_valid
                && telegram_restrictive;
        end
    end

endmodule

// ===== hw/lobe_pkg.sv
package lobe_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int POS_W = 32;
    localparam int TLG_W = 64;
    localparam int AMP_W = 8;
    localparam int CLS_W = 2;

    // ************************************************************
    // Distances in millimetres
    // ************************************************************
    localparam logic [POS_W-1:0] SAME_MAX_MM = 32'h0000_0320;
    localparam logic [POS_W-1:0] NEW_MIN_MM = 32'h0000_06A4;

    // ************************************************************
    // Telegram relation classes
    // ************************************************************
    localparam logic [CLS_W-1:0] TLG_SAME = 2'h0;
    localparam logic [CLS_W-1:0] TLG_DIFF = 2'h1;
    localparam logic [CLS_W-1:0] TLG_SAME_BCN = 2'h2;
    localparam logic [CLS_W-1:0] TLG_UNSURE = 2'h3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [POS_W-1:0] start_mm;
        logic [POS_W-1:0] end_mm;
        logic [AMP_W-1:0] peak;
        logic [TLG_W-1:0] telegram;
        logic restrictive;
    } lobe_t;

    typedef struct packed {
        logic [POS_W-1:0] location_mm;
        logic [TLG_W-1:0] telegram;
        logic restrictive;
    } beacon_t;

    typedef enum logic [1:0] {
        DIST_NEAR,
        DIST_MID,
        DIST_FAR
    } dist_t;

endpackage
